// ---- rtl/hjb_bridge.sv ----
// top of the host bus to scan pin bridge
`timescale 1ns/1ps
`default_nettype none

module hjb_bridge
  import hjb_pkg::*;
#(
  parameter int DATA_W = HJB_DATA_W
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic host_region_select_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic host_addr0,
  input wire logic host_addr1,
  input wire logic [DATA_W-1:0] host_wdata,
  input wire logic scan_tdo,
  input wire logic cable_attached,
  output logic [DATA_W-1:0] host_rdata,
  output logic host_rdata_oe,
  output logic scan_tdi,
  output logic scan_tdi_oe,
  output logic scan_clock_line,
  output logic scan_clock_line_oe,
  output logic scan_tms,
  output logic scan_tms_oe,
  output logic scan_trst_n,
  output logic scan_trst_n_oe,
  output logic program_strobe_out_n,
  output logic program_strobe_out_n_oe
);

  // the status bit and the control bit 3 must exist on the host data bus
  if (DATA_W <= HJB_TDO_BIT)
  begin : g_width_check
    $error("hjb_bridge: DATA_W must be at least 8");
  end

  // true when the host addresses the given register
  function automatic logic hjb_hit(input logic a1, input logic a0, input logic [1:0] target);
    hjb_hit = ({a1, a0} == target);
  endfunction

  logic sel;
  logic rd;
  logic wr;
  logic data_strobe;
  logic ctrl_strobe;
  logic stat_read;

  assign sel = !host_region_select_n;
  assign rd = !host_rd_n;
  assign wr = !host_wr_n;
  assign data_strobe = sel && wr && hjb_hit(host_addr1, host_addr0, HJB_ADDR_DATA);
  assign ctrl_strobe = sel && wr && hjb_hit(host_addr1, host_addr0, HJB_ADDR_CTRL);
  assign stat_read = sel && rd && hjb_hit(host_addr1, host_addr0, HJB_ADDR_CTRL);

  // access tracker: the data register loads on the first cycle of a data
  // write, which stands in for the rising edge of the looped-back strobe
  // a held write would otherwise reload each cycle and pass late bus data
  hjb_state_e state_r;
  hjb_state_e state_nxt;
  logic data_load;

  always_comb
  begin
    state_nxt = HJB_ST_IDLE;
    case (1'b1)
      data_strobe: state_nxt = HJB_ST_DATA_WR;
      ctrl_strobe: state_nxt = HJB_ST_CTRL_WR;
      stat_read: state_nxt = HJB_ST_STAT_RD;
      default: state_nxt = HJB_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_r <= HJB_ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign data_load = data_strobe && (state_r != HJB_ST_DATA_WR);

  // data port section
  logic [HJB_SCAN_W-1:0] scan_q;
  logic [HJB_SCAN_W-1:0] scan_d;

  assign scan_d[HJB_TDI_BIT] = host_wdata[HJB_TDI_BIT];
  assign scan_d[HJB_TCK_BIT] = host_wdata[HJB_TCK_BIT];
  assign scan_d[HJB_TMS_BIT] = host_wdata[HJB_TMS_BIT];

  hjb_scan_reg u_scan_reg
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(data_load),
    .d(scan_d),
    .q(scan_q)
  );

  // control port section: one latch pair per implemented bit
  logic [HJB_LAT_NUM-1:0] lat_d;
  logic [HJB_LAT_NUM-1:0] lat_master;
  logic [HJB_LAT_NUM-1:0] lat_slave;

  assign lat_d[HJB_LAT_TRST] = host_wdata[HJB_TRST_BIT];
  assign lat_d[HJB_LAT_PROG] = host_wdata[HJB_PROG_BIT];

  for (genvar i = 0; i < HJB_LAT_NUM; i++)
  begin : g_lat
    // slaves open only while the select is idle, so a slow access can never
    // leave a half-written value on the target pins
    hjb_latch_pair u_pair
    (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .master_en(ctrl_strobe),
      .d(lat_d[i]),
      .slave_en(!sel),
      .master_q(lat_master[i]),
      .slave_q(lat_slave[i])
    );
  end

  // pin and read-back registers
  logic scan_trst_n_r;
  logic scan_trst_n_nxt;
  logic prog_n_r;
  logic prog_n_nxt;
  logic pins_oe_r;
  logic pins_oe_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic rdata_oe_r;
  logic rdata_oe_nxt;

  always_comb
  begin
    // registered pins lag the slaves by one edge, so a new level may land as an access opens
    scan_trst_n_nxt = !lat_slave[HJB_LAT_TRST];
    prog_n_nxt = !lat_slave[HJB_LAT_PROG];
    // the test reset is kept driven through reset so the target controller
    // really sees it; only an attached cable releases the pins
    pins_oe_nxt = !cable_attached;
    rdata_nxt = '0;
    rdata_nxt[HJB_TDO_BIT] = scan_tdo;
    rdata_oe_nxt = stat_read;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      scan_trst_n_r <= HJB_TRST_N_RST;
      prog_n_r <= HJB_PROG_N_RST;
      pins_oe_r <= !cable_attached;
      rdata_r <= '0;
      rdata_oe_r <= 1'b0;
    end
    else
    begin
      scan_trst_n_r <= scan_trst_n_nxt;
      prog_n_r <= prog_n_nxt;
      pins_oe_r <= pins_oe_nxt;
      rdata_r <= rdata_nxt;
      rdata_oe_r <= rdata_oe_nxt;
    end
  end

  assign scan_tdi = scan_q[HJB_TDI_BIT];
  assign scan_clock_line = scan_q[HJB_TCK_BIT];
  assign scan_tms = scan_q[HJB_TMS_BIT];
  assign scan_tdi_oe = pins_oe_r;
  assign scan_clock_line_oe = pins_oe_r;
  assign scan_tms_oe = pins_oe_r;
  assign scan_trst_n = scan_trst_n_r;
  assign scan_trst_n_oe = pins_oe_r;
  assign program_strobe_out_n = prog_n_r;
  assign program_strobe_out_n_oe = pins_oe_r;
  assign host_rdata = rdata_r;
  assign host_rdata_oe = rdata_oe_r;

  default clocking cb @(posedge core_clk);
  endclocking
  // pins are registered, so most checks look one edge after their cause

  data_load_a: assert property (disable iff (!rst_n)
    data_load |=> scan_tdi == $past(host_wdata[HJB_TDI_BIT])
      && scan_clock_line == $past(host_wdata[HJB_TCK_BIT])
      && scan_tms == $past(host_wdata[HJB_TMS_BIT]))
    else $error("data write did not reach the scan pins");

  data_decode_a: assert property (disable iff (!rst_n)
    (!sel || host_addr1 || host_addr0 || !wr) |=> $stable({scan_tdi, scan_clock_line, scan_tms}))
    else $error("scan pins moved without a data port write");

  stat_drive_a: assert property (disable iff (!rst_n)
    stat_read |=> host_rdata_oe && host_rdata[HJB_TDO_BIT] == $past(scan_tdo))
    else $error("status read did not return the return line level");

  stat_quiet_a: assert property (disable iff (!rst_n)
    !stat_read |=> !host_rdata_oe)
    else $error("status bit driven outside a status read");

  stat_unused_a: assert property (disable iff (!rst_n)
    host_rdata_oe |-> host_rdata[HJB_TDO_BIT-1:0] == '0)
    else $error("unimplemented status bit not zero");

  reset_trst_a: assert property (
    !rst_n |=> !scan_trst_n && scan_trst_n_oe == !$past(cable_attached) && !host_rdata_oe)
    else $error("reset did not assert test reset");

  reset_ctrl_a: assert property (
    !rst_n ##1 rst_n |-> program_strobe_out_n && !scan_tms && !scan_tdi)
    else $error("control port not in its known state after reset");

  trst_follow_a: assert property (disable iff (!rst_n)
    lat_master[HJB_LAT_TRST] && !sel ##1 rst_n |=> !scan_trst_n)
    else $error("test reset latch did not reach the pin");

  prog_follow_a: assert property (disable iff (!rst_n)
    !sel ##1 !sel |=> program_strobe_out_n == !$past(lat_master[HJB_LAT_PROG], 2))
    else $error("program enable did not follow control bit 3");

  access_freeze_a: assert property (disable iff (!rst_n)
    sel [*3] |-> $stable(scan_trst_n) && $stable(program_strobe_out_n))
    else $error("control outputs moved during an access");

  cable_off_a: assert property (disable iff (!rst_n)
    cable_attached |=> !scan_tdi_oe && !scan_clock_line_oe && !scan_tms_oe
      && !scan_trst_n_oe && !program_strobe_out_n_oe)
    else $error("pins driven while a cable is attached");

  cable_on_a: assert property (disable iff (!rst_n)
    !cable_attached |=> scan_tdi_oe && scan_clock_line_oe && scan_tms_oe
      && scan_trst_n_oe && program_strobe_out_n_oe)
    else $error("pins not driven with no cable attached");

  data_once_a: assert property (disable iff (!rst_n)
    data_strobe ##1 data_strobe |=> $stable({scan_tdi, scan_clock_line, scan_tms}))
    else $error("held data write loaded the scan pins twice");

  ctrl_master_a: assert property (disable iff (!rst_n)
    ctrl_strobe |=> lat_master[HJB_LAT_TRST] == $past(host_wdata[HJB_TRST_BIT])
      && lat_master[HJB_LAT_PROG] == $past(host_wdata[HJB_PROG_BIT]))
    else $error("control write did not reach the master latches");

  ctrl_only_a: assert property (disable iff (!rst_n)
    !ctrl_strobe |=> $stable(lat_master))
    else $error("control latch moved without a control write");

  slave_open_a: assert property (disable iff (!rst_n)
    !sel |=> lat_slave == $past(lat_master))
    else $error("slave latches did not follow the masters while idle");

  trst_release_a: assert property (disable iff (!rst_n)
    !lat_slave[HJB_LAT_TRST] |=> scan_trst_n)
    else $error("test reset held with neither source demanding it");

  prog_on_a: assert property (disable iff (!rst_n)
    lat_slave[HJB_LAT_PROG] |=> !program_strobe_out_n)
    else $error("program enable not asserted from its latch");

  prog_off_a: assert property (disable iff (!rst_n)
    !lat_slave[HJB_LAT_PROG] |=> program_strobe_out_n)
    else $error("program enable asserted with its latch clear");

  reset_pins_a: assert property (
    !rst_n |=> !scan_tdi && !scan_clock_line && !scan_tms && program_strobe_out_n)
    else $error("reset did not clear the scan and enable pins");

  stat_other_a: assert property (disable iff (!rst_n)
    sel && rd && !hjb_hit(host_addr1, host_addr0, HJB_ADDR_CTRL) |=> !host_rdata_oe)
    else $error("read of another address drove the status bit");

endmodule

`default_nettype wire

// ---- rtl/hjb_latch_pair.sv ----
// master and slave latch pair for one control bit, sampled on the core clock
`timescale 1ns/1ps
`default_nettype none

module hjb_latch_pair
  import hjb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic master_en,
  input wire logic d,
  input wire logic slave_en,
  output logic master_q,
  output logic slave_q
);

  logic master_r;
  logic master_nxt;
  logic slave_r;
  logic slave_nxt;

  // both stages keep their value through an explicit hold path, so the
  // level never glitches while an enable falls
  always_comb
  begin
    master_nxt = master_r;
    slave_nxt = slave_r;
    if (master_en)
    begin
      master_nxt = d;
    end
    if (slave_en)
    begin
      slave_nxt = master_r;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      master_r <= HJB_LATCH_RST;
      slave_r <= HJB_LATCH_RST;
    end
    else
    begin
      master_r <= master_nxt;
      slave_r <= slave_nxt;
    end
  end

  assign master_q = master_r;
  assign slave_q = slave_r;

  master_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !master_en |=> $stable(master_r))
    else $error("master latch moved while closed");

  slave_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !slave_en |=> $stable(slave_r))
    else $error("slave latch moved while closed");

endmodule

`default_nettype wire

// ---- rtl/hjb_pkg.sv ----
// shared constants for the host bus to scan pin bridge
package hjb_pkg;

  // register select, written as {second address bit, low address bit}
  localparam logic [1:0] HJB_ADDR_DATA = 2'b00;
  localparam logic [1:0] HJB_ADDR_CTRL = 2'b01;

  // data port field positions
  localparam int HJB_TDI_BIT = 0;
  localparam int HJB_TCK_BIT = 1;
  localparam int HJB_TMS_BIT = 2;
  localparam int HJB_SCAN_W = 3;

  // control port field positions
  localparam int HJB_TRST_BIT = 0;
  localparam int HJB_PROG_BIT = 3;

  // status port field position
  localparam int HJB_TDO_BIT = 7;

  // host data width as printed
  localparam int HJB_DATA_W = 8;

  // values after reset
  localparam logic [2:0] HJB_SCAN_RST = 3'h0;
  localparam logic HJB_LATCH_RST = 1'b0;
  localparam logic HJB_TRST_N_RST = 1'b0;
  localparam logic HJB_PROG_N_RST = 1'b1;

  // index of each control latch pair
  localparam int HJB_LAT_TRST = 0;
  localparam int HJB_LAT_PROG = 1;
  localparam int HJB_LAT_NUM = 2;

  // access tracker states
  typedef enum logic [1:0]
  {
    HJB_ST_IDLE = 2'b00,
    HJB_ST_DATA_WR = 2'b01,
    HJB_ST_CTRL_WR = 2'b10,
    HJB_ST_STAT_RD = 2'b11
  } hjb_state_e;

endpackage

// ---- rtl/hjb_scan_reg.sv ----
// data port register holding the three scan pin levels
`timescale 1ns/1ps
`default_nettype none

module hjb_scan_reg
  import hjb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [HJB_SCAN_W-1:0] d,
  output logic [HJB_SCAN_W-1:0] q
);

  logic [HJB_SCAN_W-1:0] q_r;
  logic [HJB_SCAN_W-1:0] q_nxt;

  always_comb
  begin
    q_nxt = q_r;
    if (load)
    begin
      q_nxt = d;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      q_r <= HJB_SCAN_RST;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

  scan_reg_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !load |=> $stable(q_r))
    else $error("scan register changed without a load");

endmodule

`default_nettype wire

// ---- tb/hjb_host_model.sv ----
// host bus master model issuing select, strobe and address cycles
`timescale 1ns/1ps
`default_nettype none

module hjb_host_model
  import hjb_pkg::*;
(
  input wire logic core_clk,
  output logic host_region_select_n,
  output logic host_rd_n,
  output logic host_wr_n,
  output logic host_addr0,
  output logic host_addr1,
  output logic [HJB_DATA_W-1:0] host_wdata
);
  initial
  begin
    host_region_select_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    {host_addr1, host_addr0} = 2'b11;
    host_wdata = 8'h00;
  end

  // one access held for hold edges; released lines show inverted values so no stale data
  task automatic access(input logic wr, input logic [1:0] a, input logic [7:0] d,
                        input int hold);
    @(negedge core_clk);
    host_region_select_n = 1'b0;
    host_wr_n = !wr;
    host_rd_n = wr;
    {host_addr1, host_addr0} = a;
    host_wdata = d;
    repeat (hold) @(posedge core_clk);
    @(negedge core_clk);
    host_region_select_n = 1'b1;
    host_wr_n = 1'b1;
    host_rd_n = 1'b1;
    {host_addr1, host_addr0} = ~a;
    host_wdata = ~d;
  endtask
endmodule

`default_nettype wire

// ---- tb/tb_hjb_bridge.sv ----
// self-checking testbench for the host bus to scan pin bridge
`timescale 1ns/1ps
`default_nettype none

module tb_hjb_bridge
  import hjb_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n;
  logic scan_tdo;
  logic cable_attached;
  wire logic sel_n, rd_n, wr_n, a0, a1;
  wire logic [7:0] wdata;
  wire logic [7:0] rdata;
  wire logic rdata_oe, tdi, tdi_oe, tck, tck_oe, tms, tms_oe, trst_n, trst_oe;
  wire logic prog_n, prog_oe;
  wire logic [7:0] pins = {5'h0, tms, tck, tdi};
  wire logic [7:0] oes = {3'h0, tdi_oe, tck_oe, tms_oe, trst_oe, prog_oe};
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int exp_scan = 0;
  int exp_trst = 1;
  int exp_prog = 1;
  int exp_q[$];
  logic [7:0] d;
  logic [1:0] cb;

  always #25 core_clk = ~core_clk;

  hjb_host_model host (.core_clk(core_clk), .host_region_select_n(sel_n), .host_rd_n(rd_n),
    .host_wr_n(wr_n), .host_addr0(a0), .host_addr1(a1), .host_wdata(wdata));

  hjb_bridge #(.DATA_W(8)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .host_region_select_n(sel_n), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_addr0(a0),
    .host_addr1(a1), .host_wdata(wdata), .scan_tdo(scan_tdo),
    .cable_attached(cable_attached), .host_rdata(rdata), .host_rdata_oe(rdata_oe),
    .scan_tdi(tdi), .scan_tdi_oe(tdi_oe), .scan_clock_line(tck),
    .scan_clock_line_oe(tck_oe), .scan_tms(tms), .scan_tms_oe(tms_oe),
    .scan_trst_n(trst_n), .scan_trst_n_oe(trst_oe), .program_strobe_out_n(prog_n),
    .program_strobe_out_n_oe(prog_oe));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles >= 4000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    scan_tdo = 1'b0;
    cable_attached = 1'b0;
    void'($urandom(77));
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    check("scan_pins", pins, 8'h00);
    check("trst_n", 8'(trst_n), 8'h00);
    check("prog_n", 8'(prog_n), 8'h01);
    check("rdata_oe", 8'(rdata_oe), 8'h00);
    check("pin_oe", oes, 8'h1f);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    check("trst_n", 8'(trst_n), 8'(exp_trst));
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($urandom);
      host.access(1'b1, HJB_ADDR_DATA, d, 1 + (i % 3));
      exp_scan = int'(d[2:0]);
      check("scan_pins", pins, 8'(exp_scan));
      host.access(1'b1, 2'b10, ~d, 1);
      host.access(1'b1, 2'b11, ~d, 1);
      check("scan_pins", pins, 8'(exp_scan));
      host.access(1'b0, HJB_ADDR_DATA, 8'h00, 1);
      check("rdata_oe", 8'(rdata_oe), 8'h00);
      check("trst_n", 8'(trst_n), 8'(exp_trst));
      check("prog_n", 8'(prog_n), 8'(exp_prog));
    end
    for (int i = 0; i < 4; i++)
    begin
      cb = 2'(i);
      d = (8'($urandom) & 8'hf6) | {4'h0, cb[1], 2'b00, cb[0]};
      host.access(1'b1, HJB_ADDR_CTRL, d, 4);
      check("trst_n", 8'(trst_n), 8'(exp_trst));
      check("prog_n", 8'(prog_n), 8'(exp_prog));
      exp_trst = cb[0] ? 0 : 1;
      exp_prog = cb[1] ? 0 : 1;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      check("trst_n", 8'(trst_n), 8'(exp_trst));
      check("prog_n", 8'(prog_n), 8'(exp_prog));
      check("scan_pins", pins, 8'(exp_scan));
    end
    for (int i = 0; i < 8; i++)
    begin
      scan_tdo = 1'($urandom);
      exp_q.push_back(scan_tdo ? 128 : 0);
      host.access(1'b0, HJB_ADDR_CTRL, 8'h00, 1);
      check("rdata", rdata, 8'(exp_q.pop_front()));
      check("rdata_oe", 8'(rdata_oe), 8'h01);
      @(negedge core_clk);
      check("rdata_oe", 8'(rdata_oe), 8'h00);
    end
    cable_attached = 1'b1;
    @(negedge core_clk);
    check("pin_oe", oes, 8'h00);
    cable_attached = 1'b0;
    @(negedge core_clk);
    check("pin_oe", oes, 8'h1f);
    host.access(1'b1, HJB_ADDR_CTRL, 8'h09, 1);
    repeat (3) @(negedge core_clk);
    check("trst_n", 8'(trst_n), 8'h00);
    check("prog_n", 8'(prog_n), 8'h00);
    rst_n = 1'b0;
    host.access(1'b0, HJB_ADDR_CTRL, 8'h00, 1);
    check("rdata_oe", 8'(rdata_oe), 8'h00);
    check("trst_n", 8'(trst_n), 8'h00);
    check("prog_n", 8'(prog_n), 8'h01);
    check("scan_pins", pins, 8'h00);
    check("pin_oe", oes, 8'h1f);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    check("trst_n", 8'(trst_n), 8'h01);
    check("prog_n", 8'(prog_n), 8'h01);
    end_of_test();
  end
endmodule

`default_nettype wire
